// File: rtl/sflc_pkg.sv
// Package of constants and types for the serial flash lane and mode control
package sflc_pkg;

  localparam logic [7:0] OP_WRSR      = 8'h01;
  localparam logic [7:0] OP_RDSR1     = 8'h05;
  localparam logic [7:0] OP_RDSR2     = 8'h35;
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_VWREN     = 8'h50;
  localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
  localparam logic [7:0] OP_WORD_QIO  = 8'hE7;
  localparam logic [7:0] OP_OCT_QIO   = 8'hE3;
  localparam logic [7:0] OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] OP_QPI_EXIT  = 8'hFF;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;

  localparam int ADDR_BITS = 24;
  localparam int MODE_BITS = 8;
  localparam int BYTE_BITS = 8;

  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_QIO  = 4'h4;
  localparam logic [3:0] DUMMY_WQIO = 4'h2;
  localparam logic [3:0] DUMMY_OQIO = 4'h0;

  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;

  localparam int         QE_BIT      = 1;
  localparam logic [1:0] WRSR_BYTES  = 2'h2;
  localparam logic [5:0] SR1_NV_RST  = 6'h00;
  localparam logic       QE_NV_RST   = 1'b0;

  typedef enum logic [2:0] {
    PH_CMD    = 3'b000,
    PH_ADDR   = 3'b001,
    PH_DUMMY  = 3'b010,
    PH_DOUT   = 3'b011,
    PH_DIN    = 3'b100,
    PH_IGNORE = 3'b101
  } sflc_phase_t;

  typedef struct packed {
    sflc_phase_t phase;
    logic [5:0]  cnt;
    logic [3:0]  dummy;
    logic [2:0]  wid;
    logic [2:0]  owid;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic [1:0]  bidx;
    logic        osrc;
    logic [7:0]  obyte;
  } sflc_pos_t;

  typedef struct packed {
    logic       tog;
    logic [7:0] data;
    logic [1:0] idx;
  } sflc_ev_t;

  typedef struct packed {
    logic [7:0] obuf;
    logic [3:0] ocnt;
    logic [3:0] out;
    logic [3:0] oe;
  } sflc_neg_t;

  typedef struct packed {
    logic       tog_q;
    logic       cs_q;
    logic       four_lane_command_mode;
    logic       qe;
    logic       qe_nv;
    logic       hold_en;
    logic [5:0] sr1_nv;
    logic [5:0] sr1_v;
    logic       wel;
    logic       vwe;
    logic       rst_en;
    logic [7:0] last_op;
  } sflc_sys_t;

endpackage

// File: rtl/sflc_sync.sv
// Two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module sflc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [2*W-1:0] st_r;
  logic [2*W-1:0] st_nxt;

  always_comb begin
    st_nxt = {st_r[W-1:0], d_i};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r[2*W-1:W];

endmodule

// File: rtl/sflc_core.sv
// Serial flash lane width and command mode control
`timescale 1ns/1ps
module sflc_core
  import sflc_pkg::*;
#(
  parameter logic [5:0] SR1_NV_INIT = SR1_NV_RST,
  parameter logic       QE_NV_INIT  = QE_NV_RST
) (
  // System clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RSTN_I,
  // Serial link
  input  wire logic       LINK_SCK_I,
  input  wire logic       CS_N_I,
  input  wire logic [3:0] LANE_I,
  output logic      [3:0] LANE_O,
  output logic      [3:0] LANE_OE_O,
  // Read data for array reads
  input  wire logic [7:0] READ_DATA_I,
  // Mode and status
  output logic            QPI_MODE_O,
  output logic            FOUR_LANE_ENABLE_O,
  output logic            HOLD_FUNC_EN_O,
  output logic      [7:0] SR1_O,
  output logic      [7:0] SR2_O
);

  localparam sflc_pos_t POS_RST = '{
    phase: PH_CMD, cnt: 6'h00, dummy: 4'h0, wid: W1, owid: W1,
    bits: 4'h0, sh: 8'h00, bidx: 2'h0, osrc: 1'b0, obyte: 8'h00};

  sflc_pos_t pos_r;
  sflc_pos_t pos_nxt;
  sflc_ev_t  ev_r;
  sflc_ev_t  ev_nxt;
  sflc_neg_t neg_r;
  sflc_neg_t neg_nxt;
  sflc_sys_t sys_r;
  sflc_sys_t sys_nxt;

  logic [1:0] sys_s;
  logic       cs_s;
  logic       tog_s;
  logic [7:0] rd_s;
  logic [7:0] sr1_byte;
  logic [7:0] sr2_byte;

  assign cs_s     = sys_s[1];
  assign tog_s    = sys_s[0];
  assign sr1_byte = {sys_r.sr1_v, sys_r.wel, 1'b0};
  assign sr2_byte = {6'h00, sys_r.qe, 1'b0};

  // Select and event toggle into the system domain
  sflc_sync #(.W(2)) u_sys_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RSTN_I),
    .d_i     ({CS_N_I, ev_r.tog}),
    .q_o     (sys_s)
  );

  // Read data into the link domain
  sflc_sync #(.W(8)) u_rd_sync (
    .clk_i   (LINK_SCK_I),
    .rst_n_i (1'b1),
    .d_i     (READ_DATA_I),
    .q_o     (rd_s)
  );

  // Rising edge side: opcode, address, dummy and input bytes
  always_comb begin
    logic [7:0] sh;
    logic [3:0] nbits;
    logic [2:0] qw;
    logic [2:0] sw;
    sh      = 8'h00;
    nbits   = 4'h0;
    qw      = sys_r.four_lane_command_mode ? W4 : W1;
    sw      = (pos_r.phase == PH_CMD) ? qw : pos_r.wid;
    pos_nxt = pos_r;
    ev_nxt  = ev_r;
    case (sw)
      W2: begin
        sh = {pos_r.sh[5:0], LANE_I[1:0]};
      end
      W4: begin
        sh = {pos_r.sh[3:0], LANE_I};
      end
      default: begin
        sh = {pos_r.sh[6:0], LANE_I[0]};
      end
    endcase
    nbits = pos_r.bits + {1'b0, sw};
    case (pos_r.phase)
      PH_CMD: begin
        pos_nxt.sh   = sh;
        pos_nxt.bits = nbits;
        if (nbits == 4'(BYTE_BITS)) begin
          pos_nxt.bits  = 4'h0;
          pos_nxt.phase = PH_IGNORE;
          ev_nxt.tog    = ~ev_r.tog;
          ev_nxt.data   = sh;
          ev_nxt.idx    = 2'h0;
          case (sh)
            OP_RDSR1: begin
              pos_nxt.phase = PH_DOUT;
              pos_nxt.wid   = qw;
              pos_nxt.osrc  = 1'b0;
              pos_nxt.obyte = sr1_byte;
            end
            OP_RDSR2: begin
              pos_nxt.phase = PH_DOUT;
              pos_nxt.wid   = qw;
              pos_nxt.osrc  = 1'b0;
              pos_nxt.obyte = sr2_byte;
            end
            OP_WRSR: begin
              pos_nxt.phase = PH_DIN;
              pos_nxt.wid   = qw;
              pos_nxt.bidx  = 2'h0;
            end
            OP_DUAL_OUT: begin
              if (!sys_r.four_lane_command_mode) begin
                pos_nxt.phase = PH_ADDR;
                pos_nxt.wid   = W1;
                pos_nxt.cnt   = 6'(ADDR_BITS);
                pos_nxt.dummy = DUMMY_FAST;
                pos_nxt.owid  = W2;
                pos_nxt.osrc  = 1'b1;
              end
            end
            OP_DUAL_IO: begin
              if (!sys_r.four_lane_command_mode) begin
                pos_nxt.phase = PH_ADDR;
                pos_nxt.wid   = W2;
                pos_nxt.cnt   = 6'((ADDR_BITS + MODE_BITS) / 2);
                pos_nxt.dummy = 4'h0;
                pos_nxt.owid  = W2;
                pos_nxt.osrc  = 1'b1;
              end
            end
            OP_QUAD_OUT: begin
              if (sys_r.qe && !sys_r.four_lane_command_mode) begin
                pos_nxt.phase = PH_ADDR;
                pos_nxt.wid   = W1;
                pos_nxt.cnt   = 6'(ADDR_BITS);
                pos_nxt.dummy = DUMMY_FAST;
                pos_nxt.owid  = W4;
                pos_nxt.osrc  = 1'b1;
              end
            end
            OP_QUAD_IO, OP_WORD_QIO, OP_OCT_QIO: begin
              if (sys_r.qe) begin
                pos_nxt.phase = PH_ADDR;
                pos_nxt.wid   = W4;
                pos_nxt.cnt   = 6'((ADDR_BITS + MODE_BITS) / 4);
                pos_nxt.owid  = W4;
                pos_nxt.osrc  = 1'b1;
                if (sh == OP_QUAD_IO) begin
                  pos_nxt.dummy = DUMMY_QIO;
                end else if (sh == OP_WORD_QIO) begin
                  pos_nxt.dummy = DUMMY_WQIO;
                end else begin
                  pos_nxt.dummy = DUMMY_OQIO;
                end
              end
            end
            default: begin
              pos_nxt.phase = PH_IGNORE;
            end
          endcase
        end
      end
      PH_ADDR: begin
        pos_nxt.cnt = pos_r.cnt - 6'h01;
        if (pos_r.cnt == 6'h01) begin
          if (pos_r.dummy == 4'h0) begin
            pos_nxt.phase = PH_DOUT;
            pos_nxt.wid   = pos_r.owid;
          end else begin
            pos_nxt.phase = PH_DUMMY;
            pos_nxt.cnt   = {2'b00, pos_r.dummy};
          end
        end
      end
      PH_DUMMY: begin
        pos_nxt.cnt = pos_r.cnt - 6'h01;
        if (pos_r.cnt == 6'h01) begin
          pos_nxt.phase = PH_DOUT;
          pos_nxt.wid   = pos_r.owid;
        end
      end
      PH_DIN: begin
        pos_nxt.sh   = sh;
        pos_nxt.bits = nbits;
        if (nbits == 4'(BYTE_BITS)) begin
          pos_nxt.bits = 4'h0;
          pos_nxt.bidx = pos_r.bidx + 2'h1;
          ev_nxt.tog   = ~ev_r.tog;
          ev_nxt.data  = sh;
          ev_nxt.idx   = pos_r.bidx + 2'h1;
          if (pos_r.bidx + 2'h1 == WRSR_BYTES) begin
            pos_nxt.phase = PH_IGNORE;
          end
        end
      end
      default: begin
        pos_nxt = pos_r;
      end
    endcase
  end

  // Command state restarts whenever select is high
  always_ff @(posedge LINK_SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      pos_r <= POS_RST;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // Event record survives select so the toggle never jumps back
  always_ff @(posedge LINK_SCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ev_r <= '0;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  // Falling edge side: output lanes and their enables
  always_comb begin
    logic [7:0] src;
    logic [3:0] left;
    src     = 8'h00;
    left    = 4'h0;
    neg_nxt = '0;
    if (pos_r.phase == PH_DOUT) begin
      if (neg_r.ocnt == 4'h0) begin
        src  = pos_r.osrc ? rd_s : pos_r.obyte;
        left = 4'(BYTE_BITS);
      end else begin
        src  = neg_r.obuf;
        left = neg_r.ocnt;
      end
      neg_nxt.ocnt = left - {1'b0, pos_r.wid};
      case (pos_r.wid)
        W2: begin
          neg_nxt.out  = {2'b00, src[7:6]};
          neg_nxt.oe   = 4'b0011;
          neg_nxt.obuf = {src[5:0], 2'b00};
        end
        W4: begin
          neg_nxt.out  = src[7:4];
          neg_nxt.oe   = 4'b1111;
          neg_nxt.obuf = {src[3:0], 4'h0};
        end
        default: begin
          neg_nxt.out  = {2'b00, src[7], 1'b0};
          neg_nxt.oe   = 4'b0010;
          neg_nxt.obuf = {src[6:0], 1'b0};
        end
      endcase
    end
  end

  always_ff @(negedge LINK_SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      neg_r <= '0;
    end else begin
      neg_r <= neg_nxt;
    end
  end

  // System side: command mode, enables and status copies
  always_comb begin
    logic evt;
    evt           = (tog_s != sys_r.tog_q);
    sys_nxt       = sys_r;
    sys_nxt.tog_q = tog_s;
    sys_nxt.cs_q  = cs_s;
    if (cs_s && !sys_r.cs_q && sys_r.last_op == OP_WRSR) begin
      sys_nxt.wel = 1'b0;
      sys_nxt.vwe = 1'b0;
    end
    if (evt && ev_r.idx == 2'h0) begin
      sys_nxt.last_op = ev_r.data;
      sys_nxt.rst_en  = (ev_r.data == OP_RST_EN);
      case (ev_r.data)
        OP_WREN: begin
          sys_nxt.wel = 1'b1;
        end
        OP_VWREN: begin
          sys_nxt.vwe = 1'b1;
        end
        OP_RST: begin
          if (sys_r.rst_en) begin
            sys_nxt.four_lane_command_mode   = 1'b0;
            sys_nxt.sr1_v = sys_r.sr1_nv;
            sys_nxt.qe    = sys_r.qe_nv;
            sys_nxt.wel   = 1'b0;
            sys_nxt.vwe   = 1'b0;
          end
        end
        OP_QPI_ENTER: begin
          if (sys_r.qe) begin
            sys_nxt.four_lane_command_mode = 1'b1;
          end
        end
        OP_QPI_EXIT: begin
          sys_nxt.four_lane_command_mode = 1'b0;
        end
        default: begin
          sys_nxt.four_lane_command_mode = sys_r.four_lane_command_mode;
        end
      endcase
    end else if (evt && sys_r.last_op == OP_WRSR) begin
      if (ev_r.idx == 2'h1) begin
        if (sys_r.wel) begin
          sys_nxt.sr1_nv = ev_r.data[7:2];
          sys_nxt.sr1_v  = ev_r.data[7:2];
        end else if (sys_r.vwe) begin
          sys_nxt.sr1_v = ev_r.data[7:2];
        end
      end else begin
        if (sys_r.wel) begin
          sys_nxt.qe_nv = ev_r.data[QE_BIT];
          sys_nxt.qe    = ev_r.data[QE_BIT];
        end else if (sys_r.vwe) begin
          sys_nxt.qe = ev_r.data[QE_BIT];
        end
      end
    end
    sys_nxt.hold_en = ~sys_nxt.qe;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      sys_r         <= '0;
      sys_r.cs_q    <= 1'b1;
      sys_r.four_lane_command_mode     <= 1'b0;
      sys_r.sr1_nv  <= SR1_NV_INIT;
      sys_r.sr1_v   <= SR1_NV_INIT;
      sys_r.qe_nv   <= QE_NV_INIT;
      sys_r.qe      <= QE_NV_INIT;
      sys_r.hold_en <= ~QE_NV_INIT;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign LANE_O             = neg_r.out;
  assign LANE_OE_O          = neg_r.oe;
  assign QPI_MODE_O         = sys_r.four_lane_command_mode;
  assign FOUR_LANE_ENABLE_O = sys_r.qe;
  assign HOLD_FUNC_EN_O     = sys_r.hold_en;
  assign SR1_O              = sr1_byte;
  assign SR2_O              = sr2_byte;

endmodule

// File: bench/sflc_core_assertions.sv
// Checker on the ports of the lane and mode control
`timescale 1ns/1ps
module sflc_core_assertions (
  // System clock and reset
  input wire logic       CLK_SYS_I,
  input wire logic       RSTN_I,
  // Serial link
  input wire logic       LINK_SCK_I,
  input wire logic       CS_N_I,
  input wire logic [3:0] LANE_I,
  input wire logic [3:0] LANE_O,
  input wire logic [3:0] LANE_OE_O,
  input wire logic [7:0] READ_DATA_I,
  // Mode and status
  input wire logic       QPI_MODE_O,
  input wire logic       FOUR_LANE_ENABLE_O,
  input wire logic       HOLD_FUNC_EN_O,
  input wire logic [7:0] SR1_O,
  input wire logic [7:0] SR2_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_deselected;
    CS_N_I [*2];
  endsequence
  sequence s_qe_on;
    FOUR_LANE_ENABLE_O [*3];
  endsequence
  sequence s_qe_off;
    !FOUR_LANE_ENABLE_O [*3];
  endsequence
  a_lanes_released: assert property (
    s_deselected |-> LANE_OE_O == 4'h0)
    else $error("lanes driven while deselected");
  a_drive_on_fall: assert property (
    (!$stable(LANE_O) || !$stable(LANE_OE_O)) |-> !LINK_SCK_I || CS_N_I)
    else $error("lane output changed while bus clock high");
  a_hold_with_qe: assert property (
    s_qe_on |-> !HOLD_FUNC_EN_O && SR2_O == 8'h02)
    else $error("hold function or status 2 wrong with enable set");
  a_hold_without_qe: assert property (
    s_qe_off |-> HOLD_FUNC_EN_O && SR2_O == 8'h00)
    else $error("hold function or status 2 wrong with enable clear");
  a_qpi_needs_qe: assert property (
    $rose(QPI_MODE_O) |-> FOUR_LANE_ENABLE_O)
    else $error("four-lane command mode entered without enable");
  a_quad_gated: assert property (
    LANE_OE_O == 4'hF && !QPI_MODE_O |-> FOUR_LANE_ENABLE_O)
    else $error("quad output without enable");
  a_oe_shapes: assert property (
    LANE_OE_O inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable pattern");
  a_reset_mode: assert property (
    $rose(RSTN_I) |-> !QPI_MODE_O && HOLD_FUNC_EN_O && SR1_O == 8'h00)
    else $error("wrong mode after reset");
endmodule

bind sflc_core sflc_core_assertions sflc_core_assertions_i (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .LINK_SCK_I(LINK_SCK_I),
  .CS_N_I(CS_N_I), .LANE_I(LANE_I), .LANE_O(LANE_O), .LANE_OE_O(LANE_OE_O),
  .READ_DATA_I(READ_DATA_I), .QPI_MODE_O(QPI_MODE_O),
  .FOUR_LANE_ENABLE_O(FOUR_LANE_ENABLE_O), .HOLD_FUNC_EN_O(HOLD_FUNC_EN_O),
  .SR1_O(SR1_O), .SR2_O(SR2_O)
);

// File: bench/sflc_host.sv
// Host controller model, master of the serial link
`timescale 1ns/1ps
module sflc_host (
  // Link towards the device
  output logic            sck_o,
  output logic            cs_n_o,
  output logic      [3:0] lane_o,
  // Device lane drivers
  input  wire logic [3:0] dev_lane_i,
  input  wire logic [3:0] dev_oe_i
);
  logic       mode3;
  logic [3:0] drv;
  logic [3:0] hoe;
  logic [3:0] junk;
  logic [3:0] oe_seen;
  // Undriven lanes toggle so a stale value never passes
  assign lane_o = (dev_oe_i & dev_lane_i) | (~dev_oe_i & hoe & drv)
                | (~dev_oe_i & ~hoe & junk);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mode3 = 1'b0;
    drv = 4'h0;
    hoe = 4'h0;
    junk = 4'h5;
    oe_seen = 4'h0;
    cs_n_o = 1'b0;
    #1;
    cs_n_o = 1'b1; // A real select rise clears the link state
  end
  always @(sck_o) junk <= ~junk;
  task automatic sel(input logic m3);
    mode3 = m3;
    sck_o = m3;
    #40;
    cs_n_o = 1'b0;
    #20;
  endtask
  // Bits go out MSB first, higher lane holds the higher bit
  task automatic put(input int w, input int n, input logic [31:0] d);
    hoe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    for (int i = n - w; i >= 0; i -= w) begin
      sck_o = 1'b0;
      drv = 4'(d >> i);
      #16;
      sck_o = 1'b1;
      #16;
    end
  endtask
  task automatic get(input int w, input int n, output logic [31:0] q);
    hoe = 4'h0;
    q = 32'h0;
    for (int i = 0; i < n; i += w) begin
      sck_o = 1'b0;
      #16;
      sck_o = 1'b1;
      oe_seen = dev_oe_i;
      if (w == 1) q = {q[30:0], lane_o[1]};
      else q = (q << w) | 32'(lane_o & ((w == 4) ? 4'hF : 4'h3));
      #16;
    end
  endtask
  task automatic desel();
    sck_o = mode3;
    hoe = 4'h0;
    #20;
    cs_n_o = 1'b1;
    #80;
  endtask
endmodule

// File: bench/tb_top.sv
// Self-checking testbench for the lane and mode control
`timescale 1ns/1ps
module tb_top;
  import sflc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n;
  logic        sck;
  logic        cs_n;
  logic [3:0]  lane_in;
  logic [3:0]  lane_out;
  logic [3:0]  lane_oe;
  logic [7:0]  rd_data;
  logic        four_lane_command_mode;
  logic        qe;
  logic        hold_en;
  logic [7:0]  sr1;
  logic [7:0]  sr2;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          checks = 0;

  sflc_core sflc_core_i (
    .CLK_SYS_I(clk_sys), .RSTN_I(rst_n), .LINK_SCK_I(sck), .CS_N_I(cs_n),
    .LANE_I(lane_in), .LANE_O(lane_out), .LANE_OE_O(lane_oe),
    .READ_DATA_I(rd_data), .QPI_MODE_O(four_lane_command_mode), .FOUR_LANE_ENABLE_O(qe),
    .HOLD_FUNC_EN_O(hold_en), .SR1_O(sr1), .SR2_O(sr2));
  sflc_host sflc_host_i (.sck_o(sck), .cs_n_o(cs_n), .lane_o(lane_in),
    .dev_lane_i(lane_out), .dev_oe_i(lane_oe));

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic op(input logic m3, input int w, input logic [7:0] code);
    sflc_host_i.sel(m3);
    sflc_host_i.put(w, 8, {24'h000000, code});
  endtask
  task automatic op1(input int w, input logic [7:0] code);
    op(1'b0, w, code);
    sflc_host_i.desel();
  endtask
  task automatic t_reset();
    chk({7'h00, four_lane_command_mode}, 8'h00, "mode after reset");
    chk({7'h00, hold_en}, 8'h01, "hold after reset");
    chk(sr1, 8'h00, "status 1 after reset");
    chk(sr2, 8'h00, "status 2 after reset");
    chk({4'h0, lane_oe}, 8'h00, "idle lanes");
  endtask
  task automatic t_refused();
    op(1'b0, 1, OP_QUAD_OUT);
    sflc_host_i.put(1, 32, 32'h00012300);
    sflc_host_i.get(4, 8, q);
    chk({4'h0, sflc_host_i.oe_seen}, 8'h00, "quad without enable");
    sflc_host_i.desel();
    op1(1, OP_QPI_ENTER);
    chk({7'h00, four_lane_command_mode}, 8'h00, "entry without enable");
  endtask
  task automatic t_status();
    op1(1, OP_WREN);
    chk(sr1, 8'h02, "write latch");
    op(1'b0, 1, OP_WRSR);
    sflc_host_i.put(1, 16, 32'h00003C02);
    sflc_host_i.desel();
    chk(sr1, 8'h3C, "status 1 written");
    chk(sr2, 8'h02, "enable bit");
    chk({7'h00, hold_en}, 8'h00, "hold off");
    op(1'b1, 1, OP_RDSR1);
    sflc_host_i.get(1, 8, q);
    sflc_host_i.desel();
    chk(q[7:0], 8'h3C, "status 1 read in mode 3");
    op(1'b0, 1, OP_RDSR2);
    sflc_host_i.get(1, 16, q);
    sflc_host_i.desel();
    chk(q[15:8], 8'h02, "status 2 read");
    chk(q[7:0], 8'h02, "status 2 repeat");
  endtask
  task automatic t_dual();
    op(1'b0, 1, OP_DUAL_OUT);
    sflc_host_i.put(1, 32, 32'h00012300);
    sflc_host_i.get(2, 16, q);
    sflc_host_i.desel();
    chk(q[15:8], 8'h5A, "dual output data");
    chk({4'h0, sflc_host_i.oe_seen}, 8'h03, "dual lanes");
    op(1'b0, 1, OP_DUAL_IO);
    sflc_host_i.put(2, 32, 32'h00012300);
    sflc_host_i.get(2, 8, q);
    sflc_host_i.desel();
    chk(q[7:0], 8'h5A, "dual io data");
  endtask
  task automatic t_quad();
    logic [7:0] ops [4];
    logic [3:0] dm [4];
    ops = '{OP_QUAD_OUT, OP_QUAD_IO, OP_WORD_QIO, OP_OCT_QIO};
    dm = '{DUMMY_FAST, DUMMY_QIO, DUMMY_WQIO, DUMMY_OQIO};
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 1, ops[i]);
      if (i == 0) sflc_host_i.put(1, 32, 32'h00012300);
      else sflc_host_i.put(4, 32, 32'h00012300);
      if (i != 0) sflc_host_i.put(4, 4 * int'(dm[i]), 32'h0);
      sflc_host_i.get(4, 8, q);
      sflc_host_i.desel();
      chk(q[7:0], 8'h5A, "quad data");
      chk({4'h0, sflc_host_i.oe_seen}, 8'h0F, "quad lanes");
    end
  endtask
  task automatic t_qpi();
    op1(1, OP_QPI_ENTER);
    chk({7'h00, four_lane_command_mode}, 8'h01, "four-lane entry");
    op(1'b0, 4, OP_RDSR2);
    sflc_host_i.get(4, 8, q);
    sflc_host_i.desel();
    chk(q[7:0], 8'h02, "status in four-lane mode");
    op1(4, OP_RST);
    chk({7'h00, four_lane_command_mode}, 8'h01, "reset without enable");
    op1(4, OP_QPI_EXIT);
    chk({7'h00, four_lane_command_mode}, 8'h00, "four-lane exit");
    op1(1, OP_QPI_ENTER);
    op1(4, OP_VWREN);
    op(1'b0, 4, OP_WRSR);
    sflc_host_i.put(4, 16, 32'h0);
    sflc_host_i.desel();
    chk({7'h00, qe}, 8'h00, "volatile enable clear");
    op1(4, OP_RST_EN);
    op1(4, OP_RST);
    chk({7'h00, four_lane_command_mode}, 8'h00, "mode after soft reset");
    chk({7'h00, qe}, 8'h01, "enable reloaded");
    chk(sr1, 8'h3C, "status 1 reloaded");
  endtask
  task automatic wrap_up();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    rst_n = 1'b1;
    rd_data = 8'h00;
    #2;
    rst_n = 1'b0; // A real fall clears the link event record
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_data <= 8'h5A;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_refused();
    t_status();
    t_dual();
    t_quad();
    t_qpi();
    wrap_up();
  end
  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end
endmodule
